// ===== src/bit_prescaler.v
// Instruction-clock prescaler producing one-cycle tick pulses.
// Assumes a single clock domain and a free-running counter while enabled.
`timescale 1ns/1ps
`include "bit_timer_consts.vh"

module bit_prescaler #(
	parameter WIDTH = `BIT_PRE_W
) (
	input  wire       clock,
	input  wire       rst_n,
	input  wire       enable,
	input  wire [2:0] rateSelect,
	output wire       tick
);
	reg  [WIDTH-1:0] divCount;
	wire [WIDTH-1:0] divMask;

	// Select 000 keeps all eight bits (divide by 256); 111 keeps one (divide by 2)
	assign divMask = {WIDTH{1'b1}} >> rateSelect;
	assign tick    = enable && ((divCount & divMask) == divMask);

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			divCount <= `BIT_PRE_ZERO;
		else if (!enable)
			divCount <= `BIT_PRE_ZERO;
		else
			divCount <= divCount + `BIT_PRE_ONE;
	end
endmodule // bit_prescaler

// ===== src/bit_timer.v
// Basic 8-bit interval timer with mode, count, status and mask registers.
// Assumes synchronous bus strobes and an rtcClock level from a 32768 Hz oscillator.
`timescale 1ns/1ps
`include "bit_timer_consts.vh"

module bit_timer #(
	parameter RTC_DIV = `BIT_RTC_DIV
) (
	input  wire                    clock,
	input  wire                    rst_n,
	input  wire [`BIT_ADDR_W-1:0]  address,
	input  wire [7:0]              writeData,
	input  wire                    writeStrobe,
	input  wire                    readStrobe,
	input  wire                    rtcClock,
	output reg  [7:0]              readData,
	output wire                    irq,
	output wire [7:0]              irqVector,
	output reg                     wakeRequest
);
	reg  [7:0] modeReg;
	reg  [7:0] countReg;
	reg        overflowFlag;
	reg        overflowIrqEnable;
	reg        rtcMeta;
	reg        rtcSync;
	reg        rtcLast;
	reg  [`BIT_RTC_DIV_W-1:0] rtcDiv;
	reg  [7:0] next_readData;

	wire timerRunEnable   = modeReg[`BIT_RUN_BIT];
	wire rtcSourceSelect  = modeReg[`BIT_RTC_BIT];
	wire [2:0] prescaleSelect = modeReg[`BIT_RATE_HI:`BIT_RATE_LO];
	wire preTick;
	wire rtcEdge;
	wire rtcTick;
	wire countTick;
	wire overflow;
	wire writeMode   = writeStrobe && (address == `BIT_MODE_ADDR);
	wire writeCount  = writeStrobe && (address == `BIT_COUNT_ADDR);
	wire writeStatus = writeStrobe && (address == `BIT_STATUS_ADDR);
	wire writeMask   = writeStrobe && (address == `BIT_MASK_ADDR);

	bit_prescaler #(
		.WIDTH(`BIT_PRE_W)
	) prescaler (
		.clock     (clock),
		.rst_n     (rst_n),
		.enable    (timerRunEnable && !rtcSourceSelect),
		.rateSelect(prescaleSelect),
		.tick      (preTick)
	);

	// Two-flop synchroniser, edge taken from the second stage onward
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rtcMeta <= 1'b0;
			rtcSync <= 1'b0;
			rtcLast <= 1'b0;
		end
		else
		begin
			rtcMeta <= rtcClock;
			rtcSync <= rtcMeta;
			rtcLast <= rtcSync;
		end
	end

	assign rtcEdge = rtcSync && !rtcLast;

	// Divide synchronised crystal edges by RTC_DIV
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rtcDiv <= `BIT_RTC_ZERO;
		else if (!(timerRunEnable && rtcSourceSelect))
			rtcDiv <= `BIT_RTC_ZERO;
		else if (rtcEdge)
		begin
			if (rtcDiv == RTC_DIV[`BIT_RTC_DIV_W-1:0] - `BIT_RTC_ONE)
				rtcDiv <= `BIT_RTC_ZERO;
			else
				rtcDiv <= rtcDiv + `BIT_RTC_ONE;
		end
	end

	assign rtcTick = rtcEdge && (rtcDiv == RTC_DIV[`BIT_RTC_DIV_W-1:0] - `BIT_RTC_ONE);

	// Source select: prescale field ignored when RTC is chosen
	assign countTick = timerRunEnable && (rtcSourceSelect ? rtcTick : preTick);
	assign overflow  = countTick && !writeCount && (countReg == `BIT_COUNT_MAX);

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			modeReg <= `BIT_MODE_RESET;
		else if (writeMode)
			modeReg <= writeData & `BIT_MODE_WMASK;
	end

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			countReg <= `BIT_COUNT_RESET;
		else if (writeCount)
			countReg <= writeData;
		else if (countTick)
			countReg <= countReg + `BIT_COUNT_ONE;
	end

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			overflowFlag <= 1'b0;
		else if (overflow)
			overflowFlag <= 1'b1;
		else if (writeStatus && writeData[`BIT_OVF_BIT])
			overflowFlag <= 1'b0;
	end

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			overflowIrqEnable <= 1'b0;
		else if (writeMask)
			overflowIrqEnable <= writeData[`BIT_OVF_BIT];
	end

	// Wake pulse for the power controller, independent of the mask
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			wakeRequest <= 1'b0;
		else
			wakeRequest <= overflow;
	end

	assign irq       = overflowFlag && overflowIrqEnable;
	assign irqVector = `BIT_IRQ_VECTOR;

	always @*
	begin
		next_readData = `BIT_ZERO8;
		if (readStrobe)
		begin
			case (address)
				`BIT_MODE_ADDR:   next_readData = modeReg;
				`BIT_COUNT_ADDR:  next_readData = countReg;
				`BIT_STATUS_ADDR: next_readData = {7'h00, overflowFlag};
				`BIT_MASK_ADDR:   next_readData = {7'h00, overflowIrqEnable};
				default:          next_readData = `BIT_ZERO8;
			endcase
		end
	end

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			readData <= `BIT_ZERO8;
		else
			readData <= next_readData;
	end
endmodule // bit_timer

// ===== src/bit_timer_consts.vh
// Constants for the basic 8-bit interval timer: register map, fields, reset values.
// Assumes inclusion by bare name from the timer design files.
`ifndef BIT_TIMER_CONSTS_VH
`define BIT_TIMER_CONSTS_VH

`define BIT_ADDR_W         8
`define BIT_MODE_ADDR      8'hd8
`define BIT_COUNT_ADDR     8'hd9
`define BIT_STATUS_ADDR    8'hda
`define BIT_MASK_ADDR      8'hdb

`define BIT_MODE_RESET     8'h00
`define BIT_COUNT_RESET    8'h00
`define BIT_MODE_WMASK     8'hf1
`define BIT_RUN_BIT        7
`define BIT_RATE_HI        6
`define BIT_RATE_LO        4
`define BIT_RTC_BIT        0
`define BIT_OVF_BIT        0

`define BIT_COUNT_MAX      8'hff
`define BIT_COUNT_ONE      8'h01
`define BIT_ZERO8          8'h00

`define BIT_PRE_W          8
`define BIT_PRE_ONE        8'h01
`define BIT_PRE_ZERO       8'h00

`define BIT_RTC_DIV        64
`define BIT_RTC_DIV_W      6
`define BIT_RTC_ONE        6'h01
`define BIT_RTC_ZERO       6'h00

`define BIT_IRQ_VECTOR     8'h08

`endif

// ===== verif/bit_timer_monitor.sv
// Port-level checker for the interval timer.
// Assumes binding onto bit_timer; one clock domain.
`timescale 1ns/1ps
module bit_timer_monitor #(
	parameter RTC_DIV = 64
) (
	input wire       clock,
	input wire       rst_n,
	input wire [7:0] address,
	input wire [7:0] writeData,
	input wire       writeStrobe,
	input wire       readStrobe,
	input wire       rtcClock,
	input wire [7:0] readData,
	input wire       irq,
	input wire [7:0] irqVector,
	input wire       wakeRequest
);
	reg [7:0] modeShadow;
	always @(posedge clock or negedge rst_n)
		if (!rst_n) modeShadow <= 8'h00;
		else if (writeStrobe && address == 8'hd8) modeShadow <= writeData & 8'hf1;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	vector_const_a: assert property (irqVector == 8'h08)
		else $error("bad vector");
	wake_pulse_a: assert property (wakeRequest |=> !wakeRequest)
		else $error("wake too long");
	irq_rise_a: assert property ($rose(irq) && !$past(writeStrobe) |-> wakeRequest)
		else $error("irq without overflow");
	irq_fall_a: assert property ($fell(irq) |-> $past(writeStrobe))
		else $error("flag cleared by hardware");
	hold_idle_a: assert property (!$past(modeShadow[7]) |-> !wakeRequest)
		else $error("overflow while stopped");
	count_write_a: assert property (writeStrobe && address == 8'hd9 && !modeShadow[7]
		##2 readStrobe && address == 8'hd9 |=> readData == $past(writeData, 3))
		else $error("count write lost");
	unmapped_rd_a: assert property (readStrobe && (address < 8'hd8 || address > 8'hdb)
		|=> readData == 8'h00)
		else $error("unmapped read");
	mode_back_a: assert property (readStrobe && address == 8'hd8
		|=> readData == $past(modeShadow))
		else $error("mode readback");
	cover property (wakeRequest);
	cover property ($rose(irq));
	cover property ($fell(irq));
endmodule // bit_timer_monitor
bind bit_timer bit_timer_monitor #(.RTC_DIV(RTC_DIV)) mon (.clock(clock), .rst_n(rst_n),
	.address(address), .writeData(writeData), .writeStrobe(writeStrobe),
	.readStrobe(readStrobe), .rtcClock(rtcClock), .readData(readData), .irq(irq),
	.irqVector(irqVector), .wakeRequest(wakeRequest));

// ===== verif/test_bit_timer.sv
// Self-checking bench for the interval timer.
// Assumes RTC_DIV shortened to 4 and an 800 ns crystal period toggled on clock edges.
`timescale 1ns/1ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH %0t got %h want %h", $time, a, b); end end
module test_bit_timer;
	logic       clock, rst_n, writeStrobe, readStrobe, rtcClock, irq, wakeRequest;
	logic [7:0] address, writeData, readData, irqVector;
	int         errors = 0, numChecks = 0, n, r;
	bit_timer #(.RTC_DIV(4)) dut (.clock(clock), .rst_n(rst_n), .address(address),
		.writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
		.rtcClock(rtcClock), .readData(readData), .irq(irq), .irqVector(irqVector),
		.wakeRequest(wakeRequest));
	initial
	begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	initial
	begin
		rtcClock = 0;
		forever
		begin
			repeat (4) @(posedge clock);
			rtcClock <= ~rtcClock;
		end
	end
	task automatic acc(input bit w, input [7:0] a, input [7:0] d);
		@(posedge clock);
		writeStrobe <= w;
		readStrobe <= !w;
		address <= a;
		writeData <= d;
		@(posedge clock);
		writeStrobe <= 0;
		readStrobe <= 0;
		#1;
	endtask
	task automatic waitWake(output int c);
		c = 0;
		do
		begin
			@(negedge clock);
			c++;
		end
		while (!wakeRequest && c < 20000);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", numChecks, errors);
		if (errors == 0 && numChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#4000000;
		errors++;
		close_out;
	end
	initial
	begin
		{rst_n, writeStrobe, readStrobe, address, writeData} = 0;
		repeat (8) @(posedge clock);
		rst_n <= 1;
		acc(0, 8'hd8, 0);
		`CHK(readData, 8'h00)
		acc(0, 8'hd9, 0);
		`CHK(readData, 8'h00)
		acc(1, 8'hd8, 8'h7f);
		acc(0, 8'hd8, 0);
		`CHK(readData, 8'h71)
		acc(0, 8'he0, 0);
		`CHK(readData, 8'h00)
		acc(1, 8'hd8, 0);
		acc(1, 8'hd9, 8'ha5);
		acc(0, 8'hd9, 0);
		`CHK(readData, 8'ha5)
		`CHK(irqVector, 8'h08)
		$display("registers done");
		acc(1, 8'hdb, 1);
		acc(1, 8'hd9, 8'hfe);
		acc(1, 8'hd8, 8'h70);
		acc(1, 8'hd8, 8'hf0);
		waitWake(n);
		`CHK(n, 5)
		`CHK(irq, 1'b1)
		acc(0, 8'hda, 0);
		`CHK(readData, 8'h01)
		acc(1, 8'hdb, 0);
		`CHK(irq, 1'b0)
		acc(1, 8'hdb, 1);
		`CHK(irq, 1'b1)
		acc(1, 8'hda, 1);
		`CHK(irq, 1'b0)
		acc(0, 8'hda, 0);
		`CHK(readData, 8'h00)
		$display("interrupt done");
		for (r = 0; r < 8; r++)
		begin
			acc(1, 8'hd8, 8'(r << 4));
			acc(1, 8'hd9, 8'hfe);
			acc(1, 8'hd8, 8'h80 | 8'(r << 4));
			waitWake(n);
			`CHK(n, (2 << (8 - r)) + 1)
		end
		waitWake(n);
		`CHK(n, 512)
		acc(1, 8'hd8, 8'h70);
		acc(1, 8'hd9, 8'h10);
		repeat (600) @(posedge clock);
		acc(0, 8'hd9, 0);
		`CHK(readData, 8'h10)
		$display("rates done");
		acc(1, 8'hd8, 0);
		acc(1, 8'hd8, 8'h01);
		acc(1, 8'hd9, 0);
		acc(1, 8'hda, 1);
		acc(1, 8'hdb, 1);
		acc(1, 8'hd8, 8'hf1);
		waitWake(n);
		waitWake(n);
		`CHK(n, 8192)
		$display("clock source done");
		close_out;
	end
endmodule // test_bit_timer
